// >>> core/vsafd_cmd.sv
// command handler for select, reset to ready, afi and dsfid commands
`timescale 1ns/100ps
`default_nettype none
module vsafd_cmd #(
	parameter int NOMINAL_CYC = 32090,
	parameter int SLOT_CYCLES = 30200,
	parameter int SLOTS       = 2
) (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic [63:0]                own_uid,
	input  wire logic                       req_valid,
	input  wire vsafd_pkg::vsafd_req_t      req,
	input  wire logic                       req_eof,
	input  wire logic                       nvm_afi_locked,
	input  wire logic                       nvm_dsfid_locked,
	input  wire logic                       nvm_ok,
	input  wire logic                       nvm_done,
	output logic                            nvm_valid,
	output vsafd_pkg::vsafd_nvm_t           nvm_req,
	output logic                            resp_valid,
	output vsafd_pkg::vsafd_resp_t          resp,
	output vsafd_pkg::vsafd_tag_state_t     tag_state,
	output logic                            busy
);
	import vsafd_pkg::*;

	typedef enum logic [2:0] {
		VSAFD_IDLE,
		VSAFD_PROG,
		VSAFD_WAIT_EOF,
		VSAFD_WAIT_TIMER
	} vsafd_ctl_t;

	vsafd_ctl_t ctl;
	logic       timer_start;
	logic       timer_done;
	logic       timer_seen;
	logic       prog_ok;
	logic       eof_seen;
	logic       is_write;
	logic [7:0] pend_code;

	wire logic addressed  = req.flags[FLAG_ADDRESSED];
	wire logic opt_flag   = req.flags[FLAG_OPTION];
	wire logic inv_flag   = req.flags[FLAG_INVENTORY];
	wire logic uid_match  = (req.uid == own_uid);
	// answer only own UID when addressed
	wire logic for_me     = !addressed || uid_match;
	wire logic take       = req_valid && req.crc_ok && ctl == VSAFD_IDLE;
	wire logic is_sel     = req.code == CMD_SELECT;
	wire logic is_rtr     = req.code == CMD_RESET_READY;
	wire logic is_wafi    = req.code == CMD_WRITE_AFI;
	wire logic is_lafi    = req.code == CMD_LOCK_AFI;
	wire logic is_wdsf    = req.code == CMD_WRITE_DSFID;
	wire logic is_ldsf    = req.code == CMD_LOCK_DSFID;
	wire logic is_nv      = is_wafi || is_lafi || is_wdsf || is_ldsf;
	wire logic quiet      = tag_state == VSAFD_QUIET;
	// inventory flag set is an unspecified error
	wire logic bad_inv    = inv_flag;
	// select with option flag fails with 03h
	wire logic sel_err    = is_sel && (opt_flag || bad_inv);
	wire logic [7:0] sel_code = bad_inv ? ERR_GENERIC : ERR_OPTION;
	wire logic nv_locked  = (is_wafi || is_lafi) ? nvm_afi_locked : nvm_dsfid_locked;
	wire logic [7:0] lock_code = (is_wafi || is_wdsf) ? ERR_LOCKED : ERR_LOCKED_AGN;
	wire logic [7:0] fail_code = (pend_code == CMD_WRITE_AFI || pend_code == CMD_WRITE_DSFID)
		? ERR_PROG_FAIL : ERR_LOCK_FAIL;

	// timer expiry is remembered so a slow store cannot hide it
	wire logic timer_end  = timer_done || timer_seen;

	vsafd_delay #(
		.BASE_CYC (NOMINAL_CYC),
		.SLOT_CYC (SLOT_CYCLES),
		.SLOTS    (SLOTS)
	) u_delay (
		.clk    (clk),
		.resetn (resetn),
		.start  (timer_start),
		.done   (timer_done)
	);

	// tag state transitions
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tag_state <= VSAFD_READY;
		end else if (take && is_sel && !bad_inv && !opt_flag) begin
			// match selects, mismatch drops to Ready
			if (uid_match)
				tag_state <= VSAFD_SELECTED;
			else if (tag_state == VSAFD_SELECTED)
				tag_state <= VSAFD_READY;
		end else if (take && is_rtr && for_me && !bad_inv) begin
			tag_state <= VSAFD_READY;
		end
	end

	// reply and programming control
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl         <= VSAFD_IDLE;
			resp_valid  <= 1'b0;
			resp        <= '0;
			nvm_valid   <= 1'b0;
			nvm_req     <= '0;
			timer_start <= 1'b0;
			prog_ok     <= 1'b0;
			eof_seen    <= 1'b0;
			timer_seen  <= 1'b0;
			is_write    <= 1'b0;
			pend_code   <= 8'h00;
			busy        <= 1'b0;
		end else begin
			resp_valid  <= 1'b0;
			nvm_valid   <= 1'b0;
			timer_start <= 1'b0;
			unique case (ctl)
				VSAFD_IDLE: begin
					if (take && is_sel && uid_match && sel_err) begin
						resp_valid <= 1'b1;
						resp       <= '{RESP_FLAGS_ERR, sel_code, 1'b1};
					end else if (take && is_sel && uid_match) begin
						resp_valid <= 1'b1;
						resp       <= '{RESP_FLAGS_OK, 8'h00, 1'b0};
					end else if (take && is_rtr && for_me && !quiet) begin
						// reply with or without error code
						resp_valid <= 1'b1;
						resp       <= bad_inv ? vsafd_resp_t'{RESP_FLAGS_ERR, ERR_GENERIC, 1'b1}
							: vsafd_resp_t'{RESP_FLAGS_OK, 8'h00, 1'b0};
					end else if (take && is_nv && for_me) begin
						if (bad_inv) begin
							resp_valid <= 1'b1;
							resp       <= '{RESP_FLAGS_ERR, ERR_GENERIC, 1'b1};
						end else if (nv_locked) begin
							resp_valid <= 1'b1;
							resp       <= '{RESP_FLAGS_ERR, lock_code, 1'b1};
						end else begin
							nvm_valid   <= 1'b1;
							nvm_req     <= '{is_wafi, is_wdsf, is_lafi, is_ldsf, req.param};
							pend_code   <= req.code;
							is_write    <= opt_flag;
							eof_seen    <= 1'b0;
							timer_seen  <= 1'b0;
							prog_ok     <= 1'b1;
							busy        <= 1'b1;
							timer_start <= 1'b1;
							ctl         <= VSAFD_PROG;
						end
					end
				end
				VSAFD_PROG: begin
					if (req_eof)
						eof_seen <= 1'b1;
					if (timer_done)
						timer_seen <= 1'b1;
					if (nvm_done) begin
						prog_ok <= nvm_ok;
						ctl     <= VSAFD_WAIT_TIMER;
					end
				end
				VSAFD_WAIT_TIMER: begin
					if (req_eof)
						eof_seen <= 1'b1;
					// reply only after full program cycle
					if (timer_end)
						ctl <= is_write ? VSAFD_WAIT_EOF : VSAFD_IDLE;
					if (timer_end && !is_write) begin
						resp_valid <= 1'b1;
						resp       <= prog_ok ? vsafd_resp_t'{RESP_FLAGS_OK, 8'h00, 1'b0}
							: vsafd_resp_t'{RESP_FLAGS_ERR, fail_code, 1'b1};
						busy       <= 1'b0;
					end
				end
				VSAFD_WAIT_EOF: begin
					// option flag waits for reader frame end
					if (req_eof || eof_seen) begin
						resp_valid <= 1'b1;
						resp       <= prog_ok ? vsafd_resp_t'{RESP_FLAGS_OK, 8'h00, 1'b0}
							: vsafd_resp_t'{RESP_FLAGS_ERR, fail_code, 1'b1};
						busy       <= 1'b0;
						eof_seen   <= 1'b0;
						ctl        <= VSAFD_IDLE;
					end
				end
				default: ctl <= VSAFD_IDLE;
			endcase
		end
	end

	a_crc_silent: assert property (@(posedge clk) disable iff (!resetn)
		(req_valid && !req.crc_ok && ctl == VSAFD_IDLE) |=> !resp_valid && !nvm_valid)
		else $error("reply after bad crc");
	a_rtr_ready: assert property (@(posedge clk) disable iff (!resetn)
		(take && is_rtr && for_me && !bad_inv) |=> tag_state == VSAFD_READY)
		else $error("reset to ready missed");
	a_uid_quiet: assert property (@(posedge clk) disable iff (!resetn)
		(take && addressed && !uid_match) |=> !resp_valid)
		else $error("reply to foreign uid");
	a_sel_enter: assert property (@(posedge clk) disable iff (!resetn)
		(take && is_sel && uid_match && !sel_err) |=> tag_state == VSAFD_SELECTED && resp_valid)
		else $error("select not entered");
	a_sel_err: assert property (@(posedge clk) disable iff (!resetn)
		(take && is_sel && uid_match && opt_flag && !bad_inv) |=> resp_valid && resp.err_code == ERR_OPTION)
		else $error("select option error wrong");
	a_lock_err: assert property (@(posedge clk) disable iff (!resetn)
		(take && is_nv && for_me && !bad_inv && nv_locked) |=> resp_valid && resp.has_err && !nvm_valid)
		else $error("locked target programmed");
	a_lock_code: assert property (@(posedge clk) disable iff (!resetn)
		(take && (is_lafi || is_ldsf) && for_me && !bad_inv && nv_locked) |=> resp.err_code == ERR_LOCKED_AGN)
		else $error("lock code wrong");
	a_wr_code: assert property (@(posedge clk) disable iff (!resetn)
		(take && (is_wafi || is_wdsf) && for_me && !bad_inv && nv_locked) |=> resp.err_code == ERR_LOCKED)
		else $error("write lock code wrong");
	a_no_early: assert property (@(posedge clk) disable iff (!resetn)
		(ctl == VSAFD_PROG) |-> !resp_valid)
		else $error("reply during programming");
	a_eof_wait: assert property (@(posedge clk) disable iff (!resetn)
		(ctl == VSAFD_WAIT_EOF && !req_eof && !eof_seen) |=> !resp_valid)
		else $error("reply before eof");
	c_select: cover property (@(posedge clk) take && is_sel && uid_match);
	c_rtr: cover property (@(posedge clk) take && is_rtr);
	c_write: cover property (@(posedge clk) nvm_valid && nvm_req.wr_afi);
	c_eof: cover property (@(posedge clk) ctl == VSAFD_WAIT_EOF && req_eof);
endmodule
`default_nettype wire

// >>> core/vsafd_pkg.sv
// package for the state, afi and dsfid command handler
// Functional notes
// - reset to ready 26h moves tag to Ready
// - addressed mode replies only on own UID
// - option flag on reset to ready ignored
// - request is flags, code, UID, parameter, CRC
// - success reply is flags byte and CRC
// - reset to ready errors use 0Fh only
// - select errors use 03h, 0Fh
// - write AFI 27h stores family identifier
// - option flag set waits for frame end
// - program time is reply delay plus slots
// - write errors 12h locked, 13h failed
// - lock AFI 28h locks family identifier
// - lock errors 11h locked, 14h failed
// - write DSFID 29h stores format identifier
// - lock DSFID 2Ah locks format identifier
// - select matches enter Selected, others Ready
package vsafd_pkg;
	localparam logic [7:0] CMD_SELECT      = 8'h25;
	localparam logic [7:0] CMD_RESET_READY = 8'h26;
	localparam logic [7:0] CMD_WRITE_AFI   = 8'h27;
	localparam logic [7:0] CMD_LOCK_AFI    = 8'h28;
	localparam logic [7:0] CMD_WRITE_DSFID = 8'h29;
	localparam logic [7:0] CMD_LOCK_DSFID  = 8'h2A;
	localparam logic [7:0] ERR_OPTION      = 8'h03;
	localparam logic [7:0] ERR_GENERIC     = 8'h0F;
	localparam logic [7:0] ERR_LOCKED_AGN  = 8'h11;
	localparam logic [7:0] ERR_LOCKED      = 8'h12;
	localparam logic [7:0] ERR_PROG_FAIL   = 8'h13;
	localparam logic [7:0] ERR_LOCK_FAIL   = 8'h14;
	localparam logic [7:0] RESP_FLAGS_OK   = 8'h00;
	localparam logic [7:0] RESP_FLAGS_ERR  = 8'h01;
	// request flag bit positions
	localparam int FLAG_INVENTORY = 2;
	localparam int FLAG_ADDRESSED = 5;
	localparam int FLAG_OPTION    = 6;
	// timing, in ns
	localparam int NOMINAL_REPLY_DELAY_NS = 320900;
	localparam int SLOT_TIME_NS           = 302000;
	localparam int CLK_PERIOD_NS          = 10;
	localparam int NOMINAL_REPLY_CYC      = NOMINAL_REPLY_DELAY_NS / CLK_PERIOD_NS;
	localparam int SLOT_CYC               = SLOT_TIME_NS / CLK_PERIOD_NS;
	localparam int PROG_SLOTS             = 2;
	localparam logic [7:0] AFI_RESET      = 8'h00;
	localparam logic [7:0] DSFID_RESET    = 8'h00;
	typedef enum logic [1:0] {
		VSAFD_POWER_OFF,
		VSAFD_READY,
		VSAFD_QUIET,
		VSAFD_SELECTED
	} vsafd_tag_state_t;
	// decoded request from the frame receiver
	typedef struct packed {
		logic [7:0]  flags;
		logic [7:0]  code;
		logic [63:0] uid;
		logic [7:0]  param;
		logic        crc_ok;
	} vsafd_req_t;
	// reply handed to the frame transmitter
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] err_code;
		logic       has_err;
	} vsafd_resp_t;
	// request to the non-volatile store
	typedef struct packed {
		logic       wr_afi;
		logic       wr_dsfid;
		logic       lock_afi;
		logic       lock_dsfid;
		logic [7:0] data;
	} vsafd_nvm_t;
endpackage

// >>> core/vsafd_delay.sv
// program cycle timer: nominal reply delay plus whole slots
`timescale 1ns/100ps
`default_nettype none
module vsafd_delay #(
	parameter int BASE_CYC = 32090,
	parameter int SLOT_CYC = 30200,
	parameter int SLOTS    = 2
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic start,
	output logic      done
);
	localparam int TOTAL = BASE_CYC + SLOT_CYC * SLOTS;
	logic [31:0] count;
	logic        busy;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= 32'h0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count <= 32'(TOTAL - 1);
				busy  <= 1'b1;
			end else if (busy) begin
				if (count == 32'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 32'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/vsafd_nvm_model.sv
// non-volatile store model answering the handler's program and lock requests
`timescale 1ns/100ps
`default_nettype none
module vsafd_nvm_model (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 nvm_valid,
	input  wire vsafd_pkg::vsafd_nvm_t nvm_req,
	input  wire logic                 ok_in,
	input  wire logic [3:0]           lat,
	output logic                      nvm_done,
	output logic                      nvm_ok,
	output logic                      afi_locked,
	output logic                      dsfid_locked,
	output logic [7:0]                afi,
	output logic [7:0]                dsfid
);
	import vsafd_pkg::*;
	vsafd_nvm_t job;
	logic [4:0] cnt;
	// lock bits and values survive resetn
	initial begin
		{afi_locked, dsfid_locked, afi, dsfid, cnt, nvm_done, nvm_ok, job} = '0;
	end
	// answers lat+1 cycles after the request; ok level is junk outside done
	always @(posedge clk) begin
		nvm_done <= 1'b0;
		nvm_ok   <= ~ok_in;
		if (!resetn) begin
			cnt <= 5'h00;
		end else if (nvm_valid) begin
			job <= nvm_req;
			cnt <= {1'b0, lat} + 5'h01;
		end else if (cnt == 5'h01) begin
			cnt      <= 5'h00;
			nvm_done <= 1'b1;
			nvm_ok   <= ok_in;
			if (ok_in) begin
				if (job.wr_afi && !afi_locked) afi <= job.data;
				if (job.wr_dsfid && !dsfid_locked) dsfid <= job.data;
				if (job.lock_afi) afi_locked <= 1'b1;
				if (job.lock_dsfid) dsfid_locked <= 1'b1;
			end
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
		end
	end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// bench for the state, afi and dsfid command handler
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import vsafd_pkg::*;
	localparam logic [7:0] AD = 8'h20, OP = 8'h40, IV = 8'h04;
	logic             clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_eof = 1'b0, ok_in = 1'b1;
	logic [63:0]      own_uid = 64'h0;
	logic [3:0]       lat = 4'h0;
	vsafd_req_t       req = '0;
	logic             nvm_valid, nvm_done, nvm_ok, afi_lk, dsfid_lk, resp_valid, busy;
	vsafd_nvm_t       nvm_req;
	vsafd_resp_t      resp;
	vsafd_tag_state_t tag_state;
	logic [7:0]       afi, dsfid, d, wc, lc;
	logic [8:0]       e;
	logic [8:0]       expq[$];
	integer           fails = 0, tests_run = 0, seed = 70084;
	always #5 clk = ~clk;
	vsafd_cmd #(.NOMINAL_CYC(5), .SLOT_CYCLES(3), .SLOTS(1)) u_dut (.clk(clk), .resetn(resetn),
		.own_uid(own_uid), .req_valid(req_valid), .req(req), .req_eof(req_eof), .nvm_afi_locked(afi_lk),
		.nvm_dsfid_locked(dsfid_lk), .nvm_ok(nvm_ok), .nvm_done(nvm_done), .nvm_valid(nvm_valid),
		.nvm_req(nvm_req), .resp_valid(resp_valid), .resp(resp), .tag_state(tag_state), .busy(busy));
	vsafd_nvm_model u_nvm (.clk(clk), .resetn(resetn), .nvm_valid(nvm_valid), .nvm_req(nvm_req),
		.ok_in(ok_in), .lat(lat), .nvm_done(nvm_done), .nvm_ok(nvm_ok), .afi_locked(afi_lk),
		.dsfid_locked(dsfid_lk), .afi(afi), .dsfid(dsfid));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// reply watcher takes the oldest note off the queue
	always @(posedge clk) begin
		if (resp_valid === 1'b1) begin
			check(busy, 1'b0);
			if (expq.size() == 0) begin
				check(64'h1, 64'h0);
			end else begin
				e = expq.pop_front();
				check({resp.has_err, resp.flags, resp.has_err ? resp.err_code : 8'h00},
					{e[8], e[8] ? RESP_FLAGS_ERR : RESP_FLAGS_OK, e[7:0]});
			end
		end
	end
	task automatic send(input logic [7:0] fl, input logic [7:0] cd, input logic [63:0] id,
		input logic [7:0] pm, input logic ok, input logic rep, input logic [7:0] ec, input int eofd);
		int n;
		@(posedge clk);
		req       <= '{fl, cd, id, pm, ok};
		req_valid <= 1'b1;
		if (rep && eofd == 0) expq.push_back({ec != 8'h00, ec});
		@(posedge clk);
		req_valid <= 1'b0;
		// reply only released by a late frame end
		if (eofd != 0) begin
			repeat (eofd) @(posedge clk);
			req_eof <= 1'b1;
			if (rep) expq.push_back({ec != 8'h00, ec});
			@(posedge clk);
			req_eof <= 1'b0;
		end
		// no new request while programming; busy shows one edge after take
		@(posedge clk);
		for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge clk);
		repeat (3) @(posedge clk);
		check(expq.size(), 0);
	endtask
	initial begin
		own_uid = {$random(seed), $random(seed)};
		d = 8'($random(seed));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		check(tag_state, VSAFD_READY);
		send(AD, CMD_SELECT, own_uid, 0, 1, 1, 0, 0);
		check(tag_state, VSAFD_SELECTED);
		send(AD, CMD_SELECT, ~own_uid, 0, 1, 0, 0, 0);
		check(tag_state, VSAFD_READY);
		send(AD | OP, CMD_SELECT, own_uid, 0, 1, 1, ERR_OPTION, 0);
		send(AD, CMD_RESET_READY, ~own_uid, 0, 1, 0, 0, 0);
		send(8'h00, CMD_WRITE_AFI, own_uid, d, 0, 0, 0, 0);
		check(afi, 8'h00);
		// inventory flag set only to provoke the generic error
		send(AD | IV, CMD_RESET_READY, own_uid, 0, 1, 1, ERR_GENERIC, 0);
		send(AD, CMD_SELECT, own_uid, 0, 1, 1, 0, 0);
		send(AD | OP, CMD_RESET_READY, own_uid, 0, 1, 1, 0, 0);
		check(tag_state, VSAFD_READY);
		for (int k = 0; k < 2; k++) begin
			wc = k ? CMD_WRITE_DSFID : CMD_WRITE_AFI;
			lc = k ? CMD_LOCK_DSFID : CMD_LOCK_AFI;
			d = 8'($random(seed));
			lat <= 4'($random(seed));
			ok_in <= 1'b0;
			send(8'h00, wc, 0, d, 1, 1, ERR_PROG_FAIL, 0);
			ok_in <= 1'b1;
			send(AD | OP, wc, own_uid, d, 1, 1, 0, 20);
			check(k ? dsfid : afi, d);
			ok_in <= 1'b0;
			send(8'h00, lc, 0, 0, 1, 1, ERR_LOCK_FAIL, 0);
			ok_in <= 1'b1;
			send(OP, lc, 0, 0, 1, 1, 0, 20);
			send(8'h00, wc, 0, ~d, 1, 1, ERR_LOCKED, 0);
			check(k ? dsfid : afi, d);
			send(8'h00, lc, 0, 0, 1, 1, ERR_LOCKED_AGN, 0);
		end
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		send(8'h00, CMD_WRITE_AFI, 0, 8'h5A, 1, 1, ERR_LOCKED, 0);
		stop_test;
	end
	// watchdog cuts a hang short
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule
`default_nettype wire
